// ### rtl/tpo_pkg.sv
// Constants, register map and types of the time-proportioning output.
// Assumes a single 25 MHz clock and APB register access.
package tpo_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_DEMAND    = 8'h00;
	localparam logic [7:0] OFS_MIN_PULSE = 8'h04;
	localparam logic [7:0] OFS_PERIOD    = 8'h08;
	localparam logic [7:0] OFS_POLARITY  = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;

	// ==========================================================
	// Reset values and codes
	localparam logic [6:0]  RST_DEMAND       = 7'h00;
	localparam logic [15:0] RST_MIN_PULSE    = 16'h0000;
	localparam logic [15:0] RST_PERIOD       = 16'h0000;
	localparam logic [15:0] RST_POLARITY     = 16'h0000;
	localparam logic [15:0] AUTO_CODE        = 16'h0000;
	localparam logic [15:0] MIN_PULSE_AUTO_S = 16'h0001;
	localparam logic [15:0] RELAY_MIN_S      = 16'h0002;

	// ==========================================================
	// Demand scale, percent
	localparam logic [6:0] DEMAND_MAX  = 7'h64;
	localparam logic [6:0] DEMAND_HALF = 7'h32;

	// ==========================================================
	// Field positions
	localparam int POL_BIT       = 0;
	localparam int ST_RELAY_BIT  = 0;
	localparam int ST_ACTIVE_BIT = 1;
	localparam int ST_PERIOD_LSB = 16;

	// ==========================================================
	// Timebase
	localparam int CLK_HZ         = 25_000_000;
	localparam int TICK_S         = 1;
	localparam int SEC_CYCLES_DEF = CLK_HZ * TICK_S;

	typedef enum logic {ST_OFF, ST_ON} phase_t;

endpackage

// ### rtl/tpo_top.sv
// Time-proportioning output: percent demand to timed relay pulses.
// Assumes an APB master on MCLK_IN and a synchronous logic input pin.
//
// Contract
// - Auto minimum pulse code means one second
// - Manual minimum pulse clipped up to relay floor
// - Minimum pulse spaces every pair of switchings; a polarity write flips the relay at once
// - Period is in seconds, sets pattern repetition
// - Period code auto selects constant ripple mode
// - Ripple: fifty percent gives four minimum pulses
// - Nonzero period held constant for steady demand
// - Period stretched when minimum pulse would break
// - Polarity zero normal, one inverted, default normal
// - Input active on one, or zero inverted
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tpo_top
	import tpo_pkg::*;
#(
	parameter int SEC_CYCLES = tpo_pkg::SEC_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        MCLK_IN,
	input  wire logic        RST_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// Field pins
	input  wire logic        LOGIC_IN,
	output logic             RELAY_OUT,
	output logic             INPUT_ACTIVE_OUT
);
	import tpo_pkg::*;

	// ==========================================================
	// State
	logic [6:0]  demand_q, demand_d;
	logic [15:0] min_pulse_q, min_pulse_d;
	logic [15:0] period_q, period_d;
	logic [15:0] polarity_q, polarity_d;
	logic [31:0] prdata_q, prdata_d;
	logic [31:0] sec_cnt_q, sec_cnt_d;
	logic [31:0] rem_q, rem_d;
	logic [31:0] off_q, off_d;
	logic [15:0] eff_period_q, eff_period_d;
	phase_t      state_q, state_d;
	logic        relay_q, relay_d;
	logic        active_q, active_d;

	// ==========================================================
	// Combinational terms
	logic        setup, access, mapped, tick, end_ph;
	logic [15:0] eff_min;
	logic [6:0]  minor;
	logic [31:0] m32, p32, mn_c, mj_c, on_c, off_c;

	assign setup  = PSEL_IN && !PENABLE_IN;
	assign access = PSEL_IN && PENABLE_IN;
	assign mapped = (PADDR_IN == OFS_DEMAND) || (PADDR_IN == OFS_MIN_PULSE)
		|| (PADDR_IN == OFS_PERIOD) || (PADDR_IN == OFS_POLARITY)
		|| (PADDR_IN == OFS_STATUS);
	// Zero wait states keep the relay timebase independent of bus traffic
	assign PREADY_OUT       = 1'b1;
	assign PSLVERR_OUT      = access && !mapped;
	assign PRDATA_OUT       = prdata_q;
	assign RELAY_OUT        = relay_q;
	assign INPUT_ACTIVE_OUT = active_q;

	// ==========================================================
	// Pulse arithmetic
	always_comb begin
		if (min_pulse_q == AUTO_CODE) begin
			eff_min = MIN_PULSE_AUTO_S;
		end else if (min_pulse_q < RELAY_MIN_S) begin
			eff_min = RELAY_MIN_S;
		end else begin
			eff_min = min_pulse_q;
		end
		m32   = {16'h0000, eff_min};
		p32   = {16'h0000, period_q};
		minor = (demand_q > DEMAND_HALF) ? (DEMAND_MAX - demand_q) : demand_q;
		if (minor == 7'h00) begin
			// Full or zero demand: no switching, re-evaluated each minimum pulse
			mn_c = 32'h0000_0000;
			mj_c = m32;
		end else if (period_q == AUTO_CODE) begin
			// Minority grows from one to two minimum pulses at half demand;
			// both round up, so whole seconds never undercut the 4x floor
			mn_c = m32 + (m32 * 32'(minor) + 32'(DEMAND_HALF) - 32'h0000_0001)
				/ 32'(DEMAND_HALF);
			mj_c = (mn_c * 32'(DEMAND_MAX - minor) + 32'(minor) - 32'h0000_0001)
				/ 32'(minor);
		end else begin
			mn_c = (p32 * 32'(minor)) / 32'(DEMAND_MAX);
			if (mn_c < m32) begin
				mn_c = m32;
				mj_c = (m32 * 32'(DEMAND_MAX - minor)) / 32'(minor);
			end else begin
				mj_c = p32 - mn_c;
			end
		end
		on_c  = (demand_q > DEMAND_HALF) ? mj_c : mn_c;
		off_c = (demand_q > DEMAND_HALF) ? mn_c : mj_c;
	end

	// ==========================================================
	// Register file and phase sequencer
	always_comb begin
		demand_d     = demand_q;
		min_pulse_d  = min_pulse_q;
		period_d     = period_q;
		polarity_d   = polarity_q;
		prdata_d     = prdata_q;
		rem_d        = rem_q;
		off_d        = off_q;
		state_d      = state_q;
		eff_period_d = eff_period_q;
		if (access && PWRITE_IN) begin
			unique case (PADDR_IN)
				OFS_DEMAND: begin
					demand_d = (PWDATA_IN[6:0] > DEMAND_MAX || PWDATA_IN[15:7] != 9'h000)
						? DEMAND_MAX : PWDATA_IN[6:0];
				end
				OFS_MIN_PULSE: min_pulse_d = PWDATA_IN[15:0];
				OFS_PERIOD:    period_d    = PWDATA_IN[15:0];
				OFS_POLARITY:  polarity_d  = PWDATA_IN[15:0];
				default: ;
			endcase
		end
		// Read data sampled in setup so it stands through the access phase
		if (setup && !PWRITE_IN) begin
			unique case (PADDR_IN)
				OFS_DEMAND:    prdata_d = {25'h0, demand_q};
				OFS_MIN_PULSE: prdata_d = {16'h0, min_pulse_q};
				OFS_PERIOD:    prdata_d = {16'h0, period_q};
				OFS_POLARITY:  prdata_d = {16'h0, polarity_q};
				OFS_STATUS: begin
					prdata_d = 32'h0000_0000;
					prdata_d[ST_RELAY_BIT]  = relay_q;
					prdata_d[ST_ACTIVE_BIT] = active_q;
					prdata_d[ST_PERIOD_LSB +: 16] = eff_period_q;
				end
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		tick      = (sec_cnt_q == 32'(SEC_CYCLES - 1));
		sec_cnt_d = tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
		end_ph    = tick && (rem_q <= 32'h0000_0001);
		// Phases change only at second ticks and never last under the eff_min in force at their period start
		if (end_ph) begin
			if (state_q == ST_ON && off_q != 32'h0000_0000) begin
				state_d = ST_OFF;
				rem_d   = off_q;
			end else begin
				// New period; demand changes take effect only here
				eff_period_d = 16'(on_c + off_c);
				if (on_c != 32'h0000_0000) begin
					state_d = ST_ON;
					rem_d   = on_c;
					off_d   = off_c;
				end else begin
					state_d = ST_OFF;
					rem_d   = off_c;
					off_d   = 32'h0000_0000;
				end
			end
		end else if (tick) begin
			rem_d = rem_q - 32'h0000_0001;
		end
		relay_d  = (state_d == ST_ON) ^ polarity_q[POL_BIT];
		active_d = LOGIC_IN ^ polarity_q[POL_BIT];
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			demand_q     <= RST_DEMAND;
			min_pulse_q  <= RST_MIN_PULSE;
			period_q     <= RST_PERIOD;
			polarity_q   <= RST_POLARITY;
			prdata_q     <= 32'h0000_0000;
			sec_cnt_q    <= 32'h0000_0000;
			rem_q        <= 32'h0000_0000;
			off_q        <= 32'h0000_0000;
			eff_period_q <= 16'h0000;
			state_q      <= ST_OFF;
			relay_q      <= 1'b0;
			active_q     <= 1'b0;
		end else begin
			demand_q     <= demand_d;
			min_pulse_q  <= min_pulse_d;
			period_q     <= period_d;
			polarity_q   <= polarity_d;
			prdata_q     <= prdata_d;
			sec_cnt_q    <= sec_cnt_d;
			rem_q        <= rem_d;
			off_q        <= off_d;
			eff_period_q <= eff_period_d;
			state_q      <= state_d;
			relay_q      <= relay_d;
			active_q     <= active_d;
		end
	end

	// ==========================================================
	// Phase length monitor
	// Minimum latched at period start: a later write must not judge a running phase
	logic        period_start, phase_switch;
	logic [31:0] ph_sec_q, ph_sec_d;
	logic [15:0] ph_min_q, ph_min_d;

	assign period_start = end_ph && !(state_q == ST_ON && off_q != 32'h0000_0000);
	assign phase_switch = end_ph && (state_d != state_q);

	always_comb begin
		ph_sec_d = ph_sec_q;
		ph_min_d = ph_min_q;
		if (phase_switch) begin
			ph_sec_d = 32'h0000_0000;
		end else if (tick) begin
			ph_sec_d = ph_sec_q + 32'h0000_0001;
		end
		if (period_start) begin
			ph_min_d = eff_min;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			ph_sec_q <= 32'h0000_0000;
			ph_min_q <= 16'h0000;
		end else begin
			ph_sec_q <= ph_sec_d;
			ph_min_q <= ph_min_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (RST_IN);

	property p_auto_min;
		(min_pulse_q == AUTO_CODE) |-> (eff_min == MIN_PULSE_AUTO_S);
	endproperty
	a_auto_min: assert property (p_auto_min) else $error("auto minimum pulse not 1 s");

	property p_clip_min;
		(min_pulse_q != AUTO_CODE && min_pulse_q < RELAY_MIN_S) |-> (eff_min == RELAY_MIN_S);
	endproperty
	a_clip_min: assert property (p_clip_min) else $error("minimum pulse not clipped");

	property p_spacing;
		(on_c != 32'h0 |-> on_c >= m32) and (off_c != 32'h0 |-> off_c >= m32);
	endproperty
	a_spacing: assert property (p_spacing) else $error("pulse shorter than minimum");

	property p_tick_rate;
		tick |=> !tick;
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("second ticks too close");

	property p_ripple_half;
		(period_q == AUTO_CODE && demand_q == DEMAND_HALF) |-> (on_c + off_c == 4 * m32);
	endproperty
	a_ripple_half: assert property (p_ripple_half) else $error("ripple period at half wrong");

	property p_const_period;
		(period_q != AUTO_CODE && minor != 7'h00 && (p32 * 32'(minor)) / 32'(DEMAND_MAX) >= m32)
			|-> (on_c + off_c == p32);
	endproperty
	a_const_period: assert property (p_const_period) else $error("period not held");

	property p_stretch;
		(period_q != AUTO_CODE && minor != 7'h00) |-> (on_c >= m32 && off_c >= m32);
	endproperty
	a_stretch: assert property (p_stretch) else $error("period not stretched");

	property p_polarity;
		relay_q == ((state_q == ST_ON) ^ $past(polarity_q[POL_BIT]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("relay sense wrong");

	property p_input_sense;
		$past(!RST_IN) |-> (active_q == ($past(LOGIC_IN) ^ $past(polarity_q[POL_BIT])));
	endproperty
	a_input_sense: assert property (p_input_sense) else $error("input sense wrong");

	property p_on_fraction;
		(period_q != AUTO_CODE && demand_q != 7'h00 && demand_q <= DEMAND_HALF
			&& mn_c == (p32 * 32'(minor)) / 32'(DEMAND_MAX)) |-> (on_c == (p32 * 32'(demand_q)) / 32'(DEMAND_MAX));
	endproperty
	a_on_fraction: assert property (p_on_fraction) else $error("on time not demand share");

	property p_phase_len;
		phase_switch |-> (ph_sec_q + 32'h0000_0001 >= {16'h0000, ph_min_q});
	endproperty
	a_phase_len: assert property (p_phase_len) else $error("phase shorter than minimum");

	property p_ripple_floor;
		(period_q == AUTO_CODE && minor != 7'h00) |-> (on_c + off_c >= 4 * m32);
	endproperty
	a_ripple_floor: assert property (p_ripple_floor) else $error("ripple period too short");

	property p_relay_at_tick;
		$changed(relay_q) |-> ($past(tick)
			|| ($past(polarity_q[POL_BIT]) != $past(polarity_q[POL_BIT], 2)));
	endproperty
	a_relay_at_tick: assert property (p_relay_at_tick) else $error("relay switched off tick");

	property p_demand_range;
		demand_q <= DEMAND_MAX;
	endproperty
	a_demand_range: assert property (p_demand_range) else $error("demand above full scale");

endmodule

// ### testbench/relay_model.sv
// Relay model: times each steady phase of the coil drive.
// Assumes the drive changes just after a rising clock edge.
`timescale 1ns/1ps
module relay_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Coil drive
	input  wire logic        coil_in,
	// Phase report
	output logic             done_out,
	output logic             lvl_out,
	output logic      [15:0] len_out
);
	// ==========================================================
	// Phase timer
	logic        last_q;
	logic [15:0] cnt_q;
	// A coil cannot tell a glitch from a pulse, so any change ends a phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			last_q   <= 1'b0;
			cnt_q    <= 16'h0001;
			done_out <= 1'b0;
		end else if (coil_in !== last_q) begin
			done_out <= 1'b1;
			lvl_out  <= last_q;
			len_out  <= cnt_q;
			cnt_q    <= 16'h0001;
			last_q   <= coil_in;
		end else begin
			done_out <= 1'b0;
			cnt_q    <= cnt_q + 16'h0001;
		end
	end
endmodule

// ### testbench/time_proportioning_output_test.sv
// Bench of the time-proportioning output: APB set-up, phase timing, polarity.
// Assumes the package, the design and the relay model are compiled first.
`timescale 1ns/1ps
module time_proportioning_output_test;
	import tpo_pkg::*;
	// ==========================================================
	// Signals
	localparam int SEC = 10;
	logic        clk, rst, psel, penable, pwrite, logic_in, pready, pslverr;
	logic        relay, in_act, err, ph_done, ph_lvl, watch, chk_in, pol, exp_ia;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] ph_len;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	logic [7:0]  ofs[5] = '{OFS_DEMAND, OFS_MIN_PULSE, OFS_PERIOD, OFS_POLARITY, 8'h20};
	// Demand, minimum pulse, period, on seconds, off seconds
	int          cs[6][5] = '{'{50, 0, 0, 2, 2}, '{25, 0, 0, 2, 6}, '{75, 0, 0, 6, 2},
		'{50, 1, 0, 4, 4}, '{30, 0, 10, 3, 7}, '{10, 3, 4, 3, 27}};
	int          fail_count = 0;
	int          checks = 0;
	int          cyc = 0;
	int          seed = 32'h577e;

	tpo_top #(.SEC_CYCLES(SEC)) dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.LOGIC_IN(logic_in), .RELAY_OUT(relay), .INPUT_ACTIVE_OUT(in_act));
	relay_model coil (.clk_in(clk), .rst_in(rst), .coil_in(relay), .done_out(ph_done),
		.lvl_out(ph_lvl), .len_out(ph_len));

	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic s);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		s = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// Clock, input stimulus, result watchers
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (chk_in && !rst)
			chk("input_active", 32'(exp_ia), 32'(in_act));
		exp_ia   <= logic_in ^ pol;
		logic_in <= 1'($random(seed));
	end
	// Phases are only judged once a new set-up has begun its first period
	always @(posedge clk) begin
		if (watch && ph_done === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("phase", 32'(e), 32'({ph_lvl, ph_len}));
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			$display("[ERR] timeout expected done seen hung");
			finish_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, logic_in, watch, chk_in, pol} = 8'h80;
		paddr  = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[k]) begin
			apb(1'b0, ofs[k], 32'h0000_0000, rd, err);
			chk("reset_value", 32'h0000_0000, rd);
		end
		chk("slverr", 32'h0000_0001, 32'(err));
		chk_in <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, OFS_MIN_PULSE, cs[i][1], rd, err);
			apb(1'b1, OFS_PERIOD, cs[i][2], rd, err);
			apb(1'b1, OFS_DEMAND, cs[i][0], rd, err);
			// A period begun at the write edge still ran on the old demand
			repeat (2) @(posedge clk);
			do @(posedge clk); while (!(ph_done === 1'b1 && ph_lvl === 1'b0));
			exp_q.push_back({1'b1, 16'(cs[i][3] * SEC)});
			exp_q.push_back({1'b0, 16'(cs[i][4] * SEC)});
			watch <= 1'b1;
			while (exp_q.size() != 0) @(posedge clk);
			watch <= 1'b0;
			apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
			chk("period", 32'(cs[i][3] + cs[i][4]), {16'h0000, rd[31:16]});
		end
		// Over-range demand is clipped, not refused
		apb(1'b1, OFS_DEMAND, 32'h0000_00FF, rd, err);
		apb(1'b0, OFS_DEMAND, 32'h0000_0000, rd, err);
		chk("demand", 32'h0000_0064, rd);
		chk_in <= 1'b0;
		apb(1'b1, OFS_DEMAND, 32'h0000_0000, rd, err);
		apb(1'b1, OFS_POLARITY, 32'h0000_0001, rd, err);
		pol <= 1'b1;
		repeat (500) @(posedge clk);
		chk("relay", 32'h0000_0001, 32'(relay));
		chk_in <= 1'b1;
		repeat (50) @(posedge clk);
		finish_test();
	end
endmodule
